// ==== verif/lsd_load_store_decode_tb.sv ====
// Self-checking bench for the load/store decoder
`timescale 1ns/1ps
`include "lsd_defines.vh"
module lsd_load_store_decode_tb;
    reg        ref_clk = 1'b0;
    reg        rst = 1'b1;
    reg        issue = 1'b0;
    reg  [7:0] opcode = 8'h00;
    reg        data_valid = 1'b0;
    reg  [7:0] load_data = 8'h00;
    reg  [7:0] acc_value = 8'h00;
    wire       busy_r, dec_valid_r, illegal_r, done_r, x_inc_r, memory_write_r;
    wire       load_accumulator_r, load_first_index_r, load_second_index_r;
    wire       flag_we_r, flag_n_r, flag_z_r;
    wire [1:0] inst_len_r;
    wire [3:0] inst_cycles_r, addr_mode_r;
    wire [2:0] dest_r;
    wire [7:0] wr_data_r;
    integer    errors = 0, checks_done = 0, seed = 92, p, i, k;
    reg        exp_n = 1'b0, exp_z = 1'b0, extra;
    reg  [7:0] op_t [0:14] = '{8'hD5, 8'hD6, 8'hD7, 8'hD4, 8'hDB, 8'hE4, 8'h1E, 8'hCC,
                              8'hCD, 8'hDC, 8'h3E, 8'hC9, 8'hD9, 8'hD8, 8'hE5};
    reg  [1:0] len_t [0:14] = '{3, 2, 2, 1, 1, 3, 2, 2, 2, 3, 2, 2, 2, 3, 2};
    reg  [3:0] cyc_t [0:14] = '{5, 6, 6, 3, 4, 5, 2, 3, 4, 4, 2, 3, 4, 4, 4};
    reg  [2:0] dst_t [0:14] = '{1, 1, 1, 1, 1, 4, 2, 2, 2, 2, 3, 3, 3, 3, 5};
    // Addressing mode codes as numbered in the shared header
    reg  [3:0] am_t  [0:14] = '{6, 7, 8, 9, 10, 11, 1, 2, 4, 5, 1, 2, 3, 5, 2};
    reg  [7:0] bad_t [0:2]  = '{8'h00, 8'hC4, 8'hFF};

    always #2.5 ref_clk = ~ref_clk;

    lsd_load_store_decode u_lsd_load_store_decode (.ref_clk, .rst, .issue, .opcode, .data_valid,
        .load_data, .acc_value, .busy_r, .dec_valid_r, .illegal_r, .inst_len_r, .inst_cycles_r,
        .addr_mode_r, .dest_r, .done_r, .load_accumulator_r, .load_first_index_r,
        .load_second_index_r, .memory_write_r, .wr_data_r, .x_inc_r, .flag_we_r, .flag_n_r,
        .flag_z_r);

    task chk(input string nm, input [7:0] e, input [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task final_report;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One op end to end; ops of more than three cycles get a stray issue mid-op to probe the refusal
    task run_op(input [7:0] op, input [7:0] d, input [3:0] c, input [1:0] ln, input [2:0] ds,
                input [3:0] am);
        @(posedge ref_clk);
        issue <= 1'b1;
        opcode <= op;
        acc_value <= $random(seed);
        @(posedge ref_clk);
        issue <= 1'b0;
        data_valid <= (c != 0);
        load_data <= d;
        @(negedge ref_clk);
        chk("dec_valid", c != 0, dec_valid_r);
        chk("illegal", c == 0, illegal_r);
        chk("inst_len", ln, inst_len_r);
        k = 1;
        extra = 1'b0;
        while (c != 0 && done_r !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            data_valid <= 1'b0;
            issue <= (k == 1 && c > 3);
            opcode <= 8'h1E;
            @(negedge ref_clk);
            k++;
            extra = extra | dec_valid_r | illegal_r;
        end
        if (c != 0) begin
            chk("cycles", c, k);
            chk("inst_cycles", c, inst_cycles_r);
            chk("dest", ds, dest_r);
            chk("addr_mode", am, addr_mode_r);
            chk("ld_acc", ds == `LSD_DST_ACC, load_accumulator_r);
            chk("ld_x", ds == `LSD_DST_X, load_first_index_r);
            chk("ld_y", ds == `LSD_DST_Y, load_second_index_r);
            chk("mem_wr", ds >= `LSD_DST_MEM_IMM, memory_write_r);
            chk("x_inc", op == 8'hDB, x_inc_r);
            chk("wr_data", (op == 8'hE5) ? acc_value : d, wr_data_r);
            chk("flag_we", ds <= `LSD_DST_Y, flag_we_r);
            if (ds <= `LSD_DST_Y) begin
                exp_n = d[7];
                exp_z = (d == 8'h00);
            end
            chk("flag_n", exp_n, flag_n_r);
            chk("flag_z", exp_z, flag_z_r);
            chk("refused", 1'b0, extra);
        end else begin
            chk("busy", 1'b0, busy_r);
            chk("dest", `LSD_DST_NONE, dest_r);
            chk("addr_mode", `LSD_AM_NONE, addr_mode_r);
        end
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Zero, sign boundary, then random operands over every opcode
        for (p = 0; p < 3; p++) begin
            for (i = 0; i < 15; i++) begin
                run_op(op_t[i], (p == 0) ? 8'h00 : (p == 1) ? 8'h80 : $random(seed),
                       cyc_t[i], len_t[i], dst_t[i], am_t[i]);
            end
        end
        for (i = 0; i < 3; i++) begin
            run_op(bad_t[i], 8'h55, 4'h0, 2'h1, 3'h0, 4'h0);
        end
        final_report;
    end

    initial begin
        #20000;
        errors++;
        final_report;
    end
endmodule // lsd_load_store_decode_tb

bind lsd_load_store_decode lsd_properties u_lsd_properties (.ref_clk, .rst, .issue, .opcode,
    .busy_r, .dec_valid_r, .illegal_r, .inst_len_r, .done_r, .load_accumulator_r,
    .memory_write_r, .wr_data_r, .x_inc_r, .flag_we_r, .flag_n_r, .flag_z_r);

// ==== verif/lsd_properties.sv ====
// Concurrent checks on the load/store decoder ports
`timescale 1ns/1ps
module lsd_properties (
    input wire       ref_clk,
    input wire       rst,
    input wire       issue,
    input wire [7:0] opcode,
    input wire       busy_r,
    input wire       dec_valid_r,
    input wire       illegal_r,
    input wire [1:0] inst_len_r,
    input wire       done_r,
    input wire       load_accumulator_r,
    input wire       memory_write_r,
    input wire [7:0] wr_data_r,
    input wire       x_inc_r,
    input wire       flag_we_r,
    input wire       flag_n_r,
    input wire       flag_z_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Own copy of the timing table, kept apart from the design's lookup
    function automatic [3:0] cyc_of(input [7:0] op);
        case (op)
            8'h1E, 8'h3E:                             cyc_of = 4'h2;
            8'hD4, 8'hCC, 8'hC9:                      cyc_of = 4'h3;
            8'hDB, 8'hCD, 8'hDC, 8'hD9, 8'hD8, 8'hE5: cyc_of = 4'h4;
            8'hD5, 8'hE4:                             cyc_of = 4'h5;
            8'hD6, 8'hD7:                             cyc_of = 4'h6;
            default:                                  cyc_of = 4'h0;
        endcase
    endfunction

    wire       take = issue && !busy_r;
    wire [3:0] cyc  = cyc_of(opcode);

    cyc_two_a: assert property (
        take && cyc == 4'h2 |=> dec_valid_r && busy_r ##1 !busy_r && done_r)
        else $error("two-cycle op timing wrong");
    cyc_three_a: assert property (
        take && cyc == 4'h3 |=> busy_r [*2] ##1 !busy_r && done_r)
        else $error("three-cycle op timing wrong");
    cyc_four_a: assert property (
        take && cyc == 4'h4 |=> busy_r [*3] ##1 !busy_r && done_r)
        else $error("four-cycle op timing wrong");
    cyc_five_a: assert property (
        take && cyc == 4'h5 |=> busy_r [*4] ##1 !busy_r && done_r)
        else $error("five-cycle op timing wrong");
    cyc_six_a: assert property (
        take && cyc == 4'h6 |=> busy_r [*5] ##1 !busy_r && done_r)
        else $error("six-cycle op timing wrong");
    illegal_op_a: assert property (
        take && cyc == 4'h0 |=> illegal_r && !busy_r && inst_len_r == 2'h1)
        else $error("unknown opcode not flagged");
    x_inc_pair_a: assert property (x_inc_r |-> done_r && load_accumulator_r && flag_we_r)
        else $error("index increment without its load");
    store_flags_a: assert property (
        memory_write_r |-> done_r && !flag_we_r && $stable(flag_z_r) && $stable(flag_n_r))
        else $error("memory write touched flags");
    flag_value_a: assert property (
        flag_we_r |-> flag_n_r == wr_data_r[7] && flag_z_r == (wr_data_r == 8'h00))
        else $error("flags do not match loaded value");
    busy_refuse_a: assert property (busy_r && $past(busy_r) |-> !dec_valid_r && !illegal_r)
        else $error("issue accepted while busy");

    cover property (done_r && x_inc_r);
    cover property (done_r && memory_write_r);
    cover property (illegal_r);
    cover property (issue && busy_r);
endmodule // lsd_properties

// ==== verilog/lsd_decode_table.v ====
// Opcode lookup table: length, cycle count, addressing mode, destination
`timescale 1ns/1ps
`include "lsd_defines.vh"

module lsd_decode_table (
    input  wire [7:0] opcode,
    output reg        known,
    output reg  [1:0] inst_len,
    output reg  [3:0] inst_cycles,
    output reg  [3:0] addr_mode,
    output reg  [2:0] dest,
    output reg        x_inc
);

    always @* begin
        known       = 1'b1;
        inst_len    = `LSD_LEN_2;
        inst_cycles = `LSD_CYC_2;
        addr_mode   = `LSD_AM_NONE;
        dest        = `LSD_DST_NONE;
        x_inc       = 1'b0;
        case (opcode)
            `LSD_OP_LOAD_ACCUMULATOR_ABS_Y: begin
                inst_len    = `LSD_LEN_3;
                inst_cycles = `LSD_CYC_5;
                addr_mode   = `LSD_AM_ABS_Y;
                dest        = `LSD_DST_ACC;
            end
            `LSD_OP_LOAD_ACCUMULATOR_IND_X: begin
                inst_cycles = `LSD_CYC_6;
                addr_mode   = `LSD_AM_IND_DIRECT_PAGE_OPERAND_X;
                dest        = `LSD_DST_ACC;
            end
            `LSD_OP_LOAD_ACCUMULATOR_IND_Y: begin
                inst_cycles = `LSD_CYC_6;
                addr_mode   = `LSD_AM_IND_DIRECT_PAGE_OPERAND_Y;
                dest        = `LSD_DST_ACC;
            end
            `LSD_OP_LOAD_ACCUMULATOR_XPTR: begin
                inst_len    = `LSD_LEN_1;
                inst_cycles = `LSD_CYC_3;
                addr_mode   = `LSD_AM_XPTR;
                dest        = `LSD_DST_ACC;
            end
            `LSD_OP_LOAD_ACCUMULATOR_XPTR_I: begin
                inst_len    = `LSD_LEN_1;
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_XPTR_INC;
                dest        = `LSD_DST_ACC;
                x_inc       = 1'b1;
            end
            `LSD_OP_MEMORY_IMMEDIATE_WRITE: begin
                inst_len    = `LSD_LEN_3;
                inst_cycles = `LSD_CYC_5;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND_IMM;
                dest        = `LSD_DST_MEM_IMM;
            end
            `LSD_OP_LOAD_FIRST_INDEX_IMM: begin
                addr_mode   = `LSD_AM_IMM;
                dest        = `LSD_DST_X;
            end
            `LSD_OP_LOAD_FIRST_INDEX_DIRECT_PAGE_OPERAND: begin
                inst_cycles = `LSD_CYC_3;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND;
                dest        = `LSD_DST_X;
            end
            `LSD_OP_LOAD_FIRST_INDEX_DIRECT_PAGE_OPERAND_Y: begin
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND_Y;
                dest        = `LSD_DST_X;
            end
            `LSD_OP_LOAD_FIRST_INDEX_ABS: begin
                inst_len    = `LSD_LEN_3;
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_ABS;
                dest        = `LSD_DST_X;
            end
            `LSD_OP_LOAD_SECOND_INDEX_IMM: begin
                addr_mode   = `LSD_AM_IMM;
                dest        = `LSD_DST_Y;
            end
            `LSD_OP_LOAD_SECOND_INDEX_DIRECT_PAGE_OPERAND: begin
                inst_cycles = `LSD_CYC_3;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND;
                dest        = `LSD_DST_Y;
            end
            `LSD_OP_LOAD_SECOND_INDEX_DIRECT_PAGE_OPERAND_X: begin
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND_X;
                dest        = `LSD_DST_Y;
            end
            `LSD_OP_LOAD_SECOND_INDEX_ABS: begin
                inst_len    = `LSD_LEN_3;
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_ABS;
                dest        = `LSD_DST_Y;
            end
            `LSD_OP_STORE_ACCUMULATOR_DIRECT_PAGE_OPERAND: begin
                inst_cycles = `LSD_CYC_4;
                addr_mode   = `LSD_AM_DIRECT_PAGE_OPERAND;
                dest        = `LSD_DST_MEM_ACC;
            end
            default: begin
                known       = 1'b0;
                inst_len    = `LSD_LEN_1;
            end
        endcase
    end

endmodule // lsd_decode_table

// ==== verilog/lsd_defines.vh ====
// Opcodes, lengths, cycle counts and field codes of the load/store decoder
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH

`define LSD_OP_LOAD_ACCUMULATOR_ABS_Y                8'hD5
`define LSD_OP_LOAD_ACCUMULATOR_IND_X                8'hD6
`define LSD_OP_LOAD_ACCUMULATOR_IND_Y                8'hD7
`define LSD_OP_LOAD_ACCUMULATOR_XPTR                 8'hD4
`define LSD_OP_LOAD_ACCUMULATOR_XPTR_I               8'hDB
`define LSD_OP_MEMORY_IMMEDIATE_WRITE                8'hE4
`define LSD_OP_LOAD_FIRST_INDEX_IMM                  8'h1E
`define LSD_OP_LOAD_FIRST_INDEX_DIRECT_PAGE_OPERAND  8'hCC
`define LSD_OP_LOAD_FIRST_INDEX_DIRECT_PAGE_OPERAND_Y 8'hCD
`define LSD_OP_LOAD_FIRST_INDEX_ABS                  8'hDC
`define LSD_OP_LOAD_SECOND_INDEX_IMM                 8'h3E
`define LSD_OP_LOAD_SECOND_INDEX_DIRECT_PAGE_OPERAND 8'hC9
`define LSD_OP_LOAD_SECOND_INDEX_DIRECT_PAGE_OPERAND_X 8'hD9
`define LSD_OP_LOAD_SECOND_INDEX_ABS                 8'hD8
`define LSD_OP_STORE_ACCUMULATOR_DIRECT_PAGE_OPERAND 8'hE5

`define LSD_LEN_1          2'h1
`define LSD_LEN_2          2'h2
`define LSD_LEN_3          2'h3

`define LSD_CYC_2          4'h2
`define LSD_CYC_3          4'h3
`define LSD_CYC_4          4'h4
`define LSD_CYC_5          4'h5
`define LSD_CYC_6          4'h6

// Count value seen in the final busy cycle of any instruction
`define LSD_CNT_LAST       4'h2

// Addressing modes
`define LSD_AM_NONE        4'h0
`define LSD_AM_IMM         4'h1
`define LSD_AM_DIRECT_PAGE_OPERAND       4'h2
`define LSD_AM_DIRECT_PAGE_OPERAND_X     4'h3
`define LSD_AM_DIRECT_PAGE_OPERAND_Y     4'h4
`define LSD_AM_ABS                       4'h5
`define LSD_AM_ABS_Y                     4'h6
`define LSD_AM_IND_DIRECT_PAGE_OPERAND_X 4'h7
`define LSD_AM_IND_DIRECT_PAGE_OPERAND_Y 4'h8
`define LSD_AM_XPTR                      4'h9
`define LSD_AM_XPTR_INC                  4'hA
`define LSD_AM_DIRECT_PAGE_OPERAND_IMM   4'hB

// Destinations
`define LSD_DST_NONE       3'h0
`define LSD_DST_ACC        3'h1
`define LSD_DST_X          3'h2
`define LSD_DST_Y          3'h3
`define LSD_DST_MEM_IMM    3'h4
`define LSD_DST_MEM_ACC    3'h5

`endif

// ==== verilog/lsd_load_store_decode.v ====
// Load/store instruction decoder with execution timing and writeback
`timescale 1ns/1ps
`include "lsd_defines.vh"

module lsd_load_store_decode (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       issue,
    input  wire [7:0] opcode,
    input  wire       data_valid,
    input  wire [7:0] load_data,
    input  wire [7:0] acc_value,
    output reg        busy_r,
    output reg        dec_valid_r,
    output reg        illegal_r,
    output reg  [1:0] inst_len_r,
    output reg  [3:0] inst_cycles_r,
    output reg  [3:0] addr_mode_r,
    output reg  [2:0] dest_r,
    output reg        done_r,
    output reg        load_accumulator_r,
    output reg        load_first_index_r,
    output reg        load_second_index_r,
    output reg        memory_write_r,
    output reg  [7:0] wr_data_r,
    output reg        x_inc_r,
    output reg        flag_we_r,
    output reg        flag_n_r,
    output reg        flag_z_r
);

    wire       tbl_known;
    wire [1:0] tbl_len;
    wire [3:0] tbl_cycles;
    wire [3:0] tbl_mode;
    wire [2:0] tbl_dest;
    wire       tbl_x_inc;

    reg  [3:0] cnt_r;
    reg  [7:0] data_r;
    reg        x_inc_pend_r;
    reg  [7:0] data_sel;
    reg        last_cycle;
    reg        is_load;

    wire       take = issue && !busy_r;

    lsd_decode_table u_table (
        .opcode      (opcode),
        .known       (tbl_known),
        .inst_len    (tbl_len),
        .inst_cycles (tbl_cycles),
        .addr_mode   (tbl_mode),
        .dest        (tbl_dest),
        .x_inc       (tbl_x_inc)
    );

    // Operand arriving in the final cycle is used directly, saving a cycle of latency
    always @* begin
        data_sel   = data_valid ? load_data : data_r;
        last_cycle = busy_r && (cnt_r == `LSD_CNT_LAST);
        is_load    = (dest_r == `LSD_DST_ACC) || (dest_r == `LSD_DST_X) ||
                     (dest_r == `LSD_DST_Y);
    end

    // Issue, cycle count and decode fields
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r        <= 1'b0;
            cnt_r         <= 4'h0;
            dec_valid_r   <= 1'b0;
            illegal_r     <= 1'b0;
            inst_len_r    <= 2'h0;
            inst_cycles_r <= 4'h0;
            addr_mode_r   <= `LSD_AM_NONE;
            dest_r        <= `LSD_DST_NONE;
            x_inc_pend_r  <= 1'b0;
        end else begin
            dec_valid_r <= take && tbl_known;
            illegal_r   <= take && !tbl_known;
            if (take) begin
                inst_len_r    <= tbl_len;
                inst_cycles_r <= tbl_cycles;
                addr_mode_r   <= tbl_mode;
                dest_r        <= tbl_dest;
                x_inc_pend_r  <= tbl_x_inc;
                if (tbl_known) begin
                    // Opcode fetch was cycle 0; busy covers the remaining cycles
                    busy_r <= 1'b1;
                    cnt_r  <= tbl_cycles;
                end
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
                if (cnt_r == `LSD_CNT_LAST) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // Operand capture while the instruction runs
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_r <= 8'h00;
        end else if (take) begin
            data_r <= 8'h00;
        end else if (busy_r && data_valid) begin
            data_r <= load_data;
        end
    end

    // Writeback in the final cycle of the instruction
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_r              <= 1'b0;
            load_accumulator_r  <= 1'b0;
            load_first_index_r  <= 1'b0;
            load_second_index_r <= 1'b0;
            memory_write_r      <= 1'b0;
            wr_data_r           <= 8'h00;
            x_inc_r             <= 1'b0;
            flag_we_r           <= 1'b0;
            flag_n_r            <= 1'b0;
            flag_z_r            <= 1'b0;
        end else begin
            done_r              <= last_cycle;
            load_accumulator_r  <= last_cycle && (dest_r == `LSD_DST_ACC);
            load_first_index_r  <= last_cycle && (dest_r == `LSD_DST_X);
            load_second_index_r <= last_cycle && (dest_r == `LSD_DST_Y);
            memory_write_r      <= last_cycle && ((dest_r == `LSD_DST_MEM_IMM) ||
                                                  (dest_r == `LSD_DST_MEM_ACC));
            x_inc_r             <= last_cycle && x_inc_pend_r;
            // Store leaves flags alone; carry is never driven here
            flag_we_r           <= last_cycle && is_load;
            if (last_cycle) begin
                if (dest_r == `LSD_DST_MEM_ACC) begin
                    wr_data_r <= acc_value;
                end else begin
                    wr_data_r <= data_sel;
                end
                if (is_load) begin
                    flag_n_r <= data_sel[7];
                    flag_z_r <= (data_sel == 8'h00);
                end
            end
        end
    end

endmodule // lsd_load_store_decode
